// ---- passive_serial_config_sequencer_tb.sv ----
// bench joining host and device ends across the configuration link
module passive_serial_config_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0;
  logic reset_n = 1'h0;
  logic start = 1'h0;
  logic wrValid = 1'h0;
  logic userClkRun = 1'h0;
  logic useUserClock = 1'h0;
  logic cableMode = 1'h0;
  logic injectError = 1'h0;
  psc_pkg::psc_len_t nBytes = 24'h10;
  psc_pkg::psc_byte_t wrData = 8'h00;
  psc_pkg::psc_byte_t gotByte;
  logic wrReady, busy, hostUser, hostErr, byteValid, chainErr, devUser;
  int miscompares = 0;
  int cmp_count = 0;
  psc_pkg::psc_byte_t rxQ[$];
  psc_link_if lk();
  psc_host #(.Cf2ckCycles(60)) psc_host_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .link(lk.host), .start(start), .bitstreamBytes(nBytes), .wrData(wrData),
    .wrValid(wrValid), .wrReady(wrReady), .userClkRun(userClkRun), .busy_r(busy),
    .userMode_r(hostUser), .error_r(hostErr));
  psc_device #(.PorCycles(50), .StatusMinCycles(40), .StartupCycles(60)) psc_device_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .link(lk.dev), .useUserClock(useUserClock),
    .cableMode(cableMode), .injectError(injectError), .bitstreamBits(nBytes << 3),
    .cfgByte_r(gotByte), .cfgByteValid_r(byteValid), .chainError_r(chainErr),
    .userMode_r(devUser));
  psc_link_sva psc_link_sva_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .config_request_n(lk.config_request_n),
    .config_clock(lk.config_clock), .status_n(lk.status_n), .config_done(lk.config_done),
    .init_complete(lk.init_complete));
  // 200 MHz clock
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // collect bytes assembled by the device
  always @(negedge ref_clk) begin
    if (byteValid === 1'h1) rxQ.push_back(gotByte);
  end
  function automatic psc_pkg::psc_byte_t pat(input int i);
    return (8'h1d * i[7:0]) ^ 8'ha5;
  endfunction
  function automatic logic cond(input int sel);
    if (sel == 0) return hostUser === 1'h1 && devUser === 1'h1;
    if (sel == 1) return hostErr === 1'h1 && chainErr === 1'h1;
    return rxQ.size() >= 2;
  endfunction
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'h1) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // bounded wait on a condition, returns cycles spent
  task automatic wait_cond(input int sel, output int n);
    n = 0;
    while (!cond(sel) && n < 60000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 60000) begin
      check(1'h0, "wait timed out");
      complete_run();
    end
  endtask
  // reset with status and done held low through power-on delay
  task automatic do_reset();
    reset_n = 1'h0;
    repeat (16) @(negedge ref_clk);
    check(lk.status_n === 1'h0 && lk.config_done === 1'h0, "lines high in reset");
    reset_n = 1'h1;
    repeat (40) @(negedge ref_clk);
    check(lk.status_n === 1'h0, "status released in power-on delay");
    repeat (160) @(negedge ref_clk);
    check(lk.status_n === 1'h1, "status not released");
  endtask
  // fill fifo to full, configure, compare bytes or halt on error
  task automatic run_cfg(input logic uClk, input logic cable, input logic err);
    int n;
    rxQ.delete();
    useUserClock = uClk;
    cableMode = cable;
    userClkRun = uClk && !cable;
    for (int i = 0; i < 16; i++) begin
      wrData = pat(i);
      wrValid = 1'h1;
      @(negedge ref_clk);
    end
    wrValid = 1'h0;
    check(wrReady === 1'h0, "fifo not full after 16 words");
    start = 1'h1;
    @(negedge ref_clk);
    start = 1'h0;
    @(negedge ref_clk);
    check(busy === 1'h1 && lk.config_request_n === 1'h0, "request not raised");
    if (err) begin
      wait_cond(2, n);
      injectError = 1'h1;
      wait_cond(1, n);
      check(lk.status_n === 1'h0 && lk.config_done === 1'h0 && busy === 1'h0,
            "chain not halted");
      injectError = 1'h0;
    end else begin
      wait_cond(0, n);
      check((n > 51072) === (uClk && !cable), "startup clock use wrong");
      check(rxQ.size() == 16, "byte count wrong");
      for (int i = 0; i < 16; i++) check(rxQ[i] === pat(i), "byte wrong");
      check(lk.init_complete === 1'h1 && lk.config_done === 1'h1 && busy === 1'h0,
            "not in user mode");
    end
  endtask
  // main sequence
  initial begin
    do_reset();
    run_cfg(1'h0, 1'h0, 1'h0);
    run_cfg(1'h1, 1'h1, 1'h0);
    run_cfg(1'h1, 1'h0, 1'h0);
    run_cfg(1'h0, 1'h0, 1'h1);
    do_reset();
    run_cfg(1'h0, 1'h0, 1'h0);
    complete_run();
  end
endmodule

// ---- psc_device.sv ----
// device end: reset handshake, serial bit intake, startup and user mode
`include "psc_params.svh"
module psc_device #(
  parameter int unsigned PorCycles = `PSC_POR_CYC,
  parameter int unsigned StatusMinCycles = `PSC_STATUS_MIN_CYC,
  parameter int unsigned StartupCycles = `PSC_CD2UM_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  psc_link_if.dev link,
  input wire logic useUserClock,
  input wire logic cableMode,
  input wire logic injectError,
  input wire psc_pkg::psc_len_t bitstreamBits,
  output psc_pkg::psc_byte_t cfgByte_r,
  output logic cfgByteValid_r,
  output logic chainError_r,
  output logic userMode_r
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // saturating count so long stretches never wrap
  function automatic psc_pkg::psc_cnt_t incSat(input psc_pkg::psc_cnt_t c);
    incSat = (&c) ? c : c + psc_pkg::psc_cnt_t'(1);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pinRaw;
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic [5:0] sync3_r;
  logic [5:0] pinFlt_r;
  logic [5:0] pinPrev_r;

  assign pinRaw = {link.config_request_n, link.status_n, link.config_done,
                   link.user_startup_clock, link.serial_config_data, link.config_clock};

  // three flops; a bit changes once stages two and three agree
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= `PSC_SYNC_RST;
      sync2_r <= `PSC_SYNC_RST;
      sync3_r <= `PSC_SYNC_RST;
      pinFlt_r <= `PSC_SYNC_RST;
      pinPrev_r <= `PSC_SYNC_RST;
    end else begin
      sync1_r <= pinRaw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pinFlt_r <= (sync2_r & ~(sync2_r ^ sync3_r)) | (pinFlt_r & (sync2_r ^ sync3_r));
      pinPrev_r <= pinFlt_r;
    end
  end

  logic req;
  logic reqFall;
  logic statusFall;
  logic doneWire;
  logic usrRise;
  logic dataBit;
  logic clkRise;
  logic clkFall;

  assign req = pinFlt_r[5];
  assign reqFall = pinPrev_r[5] & ~pinFlt_r[5];
  assign statusFall = pinPrev_r[4] & ~pinFlt_r[4];
  assign doneWire = pinFlt_r[3];
  assign usrRise = ~pinPrev_r[2] & pinFlt_r[2];
  assign dataBit = pinFlt_r[1];
  assign clkRise = ~pinPrev_r[0] & pinFlt_r[0];
  assign clkFall = pinPrev_r[0] & ~pinFlt_r[0];

  // ----------------------------------------------------------------
  // sequence state
  // ----------------------------------------------------------------
  psc_pkg::psc_dev_e state_r;
  psc_pkg::psc_cnt_t cnt_r;
  psc_pkg::psc_len_t bitCnt_r;
  logic fallCnt_r;
  logic usrEn_r;
  logic [11:0] usrCnt_r;
  logic lastBit;
  logic userClkMode;

  assign lastBit = clkRise && (bitCnt_r == bitstreamBits - psc_pkg::psc_len_t'(1));
  assign userClkMode = useUserClock && !cableMode;

  // main sequence with its timer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= psc_pkg::DEV_POR;
      cnt_r <= '0;
      fallCnt_r <= 1'h0;
      usrEn_r <= 1'h0;
      usrCnt_r <= 12'h000;
    end else if (!req && state_r != psc_pkg::DEV_POR) begin
      state_r <= psc_pkg::DEV_RESET;
      cnt_r <= reqFall ? '0 : incSat(cnt_r);
    end else begin
      unique case (state_r)
        psc_pkg::DEV_POR: begin
          cnt_r <= incSat(cnt_r);
          if (cnt_r >= psc_pkg::psc_cnt_t'(PorCycles - 1)) begin
            state_r <= psc_pkg::DEV_RESET;
            cnt_r <= '0;
          end
        end
        psc_pkg::DEV_RESET: begin
          cnt_r <= incSat(cnt_r);
          fallCnt_r <= 1'h0;
          usrEn_r <= 1'h0;
          usrCnt_r <= 12'h000;
          // request is high here, release once the minimum low time is met
          if (cnt_r >= psc_pkg::psc_cnt_t'(StatusMinCycles - 1)) begin
            state_r <= psc_pkg::DEV_CONFIG;
            cnt_r <= '0;
          end
        end
        psc_pkg::DEV_CONFIG: begin
          if (statusFall || injectError) begin
            state_r <= psc_pkg::DEV_HALT;
          end else if (lastBit) begin
            state_r <= psc_pkg::DEV_INIT;
          end
        end
        psc_pkg::DEV_INIT: begin
          // falling edges count only once every tied done line is high
          if (statusFall) begin
            state_r <= psc_pkg::DEV_HALT;
          end else if (clkFall && doneWire) begin
            fallCnt_r <= 1'h1;
            if (fallCnt_r) begin
              state_r <= psc_pkg::DEV_START;
              cnt_r <= '0;
            end
          end
        end
        psc_pkg::DEV_START: begin
          cnt_r <= incSat(cnt_r);
          if (!userClkMode) begin
            if (cnt_r >= psc_pkg::psc_cnt_t'(StartupCycles - 1)) begin
              state_r <= psc_pkg::DEV_USER;
            end
          end else if (!usrEn_r) begin
            if (cnt_r >= psc_pkg::psc_cnt_t'(`PSC_CD2CU_CYC - 1)) begin
              usrEn_r <= 1'h1;
            end
          end else if (usrRise) begin
            usrCnt_r <= usrCnt_r + 12'h001;
            if (usrCnt_r == 12'(`PSC_USERCLK_EDGES - 1)) begin
              state_r <= psc_pkg::DEV_USER;
            end
          end
        end
        psc_pkg::DEV_USER: begin
          state_r <= psc_pkg::DEV_USER;
        end
        psc_pkg::DEV_HALT: begin
          state_r <= psc_pkg::DEV_HALT;
        end
        default: begin
          state_r <= psc_pkg::DEV_HALT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // serial intake
  // ----------------------------------------------------------------
  psc_pkg::psc_byte_t shift_r;
  logic [2:0] bitIdx_r;
  psc_pkg::psc_byte_t shiftNxt;

  assign shiftNxt = {dataBit, shift_r[7:1]}; // first bit lands in bit 0

  // bits taken on rising clock edges, gathered into bytes
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_r <= 8'h00;
      bitIdx_r <= 3'h0;
      bitCnt_r <= '0;
      cfgByte_r <= 8'h00;
      cfgByteValid_r <= 1'h0;
    end else begin
      cfgByteValid_r <= 1'h0;
      if (state_r != psc_pkg::DEV_CONFIG) begin
        bitIdx_r <= 3'h0;
        if (state_r == psc_pkg::DEV_RESET) begin
          bitCnt_r <= '0;
        end
      end else if (clkRise && req) begin
        shift_r <= shiftNxt;
        bitIdx_r <= bitIdx_r + 3'h1;
        bitCnt_r <= bitCnt_r + psc_pkg::psc_len_t'(1);
        if (bitIdx_r == 3'h7) begin
          cfgByte_r <= shiftNxt;
          cfgByteValid_r <= 1'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic statusLow;
  logic doneLow;

  assign statusLow = !req || state_r == psc_pkg::DEV_POR || state_r == psc_pkg::DEV_RESET
                     || state_r == psc_pkg::DEV_HALT;
  assign doneLow = !req || state_r == psc_pkg::DEV_POR || state_r == psc_pkg::DEV_RESET
                   || state_r == psc_pkg::DEV_HALT
                   || (state_r == psc_pkg::DEV_CONFIG && !lastBit);

  // status and done drivers, pulled low a few cycles after a request fall
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      link.statusOut <= 1'h0;
      link.statusOe <= 1'h1;
      link.doneOut <= 1'h0;
      link.doneOe <= 1'h1;
    end else begin
      link.statusOut <= 1'h0;
      link.statusOe <= statusLow;
      link.doneOut <= 1'h0;
      link.doneOe <= doneLow;
    end
  end

  // user mode and error reporting
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      link.init_complete <= 1'h0;
      userMode_r <= 1'h0;
      chainError_r <= 1'h0;
    end else begin
      link.init_complete <= state_r == psc_pkg::DEV_USER;
      userMode_r <= state_r == psc_pkg::DEV_USER;
      chainError_r <= state_r == psc_pkg::DEV_HALT;
    end
  end

endmodule

// ---- psc_host.sv ----
// host end: byte fifo and the request, clock and data sequencer
`include "psc_params.svh"
module psc_fifo #(
  parameter int Width = `PSC_BYTE_W,
  parameter int Depth = `PSC_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [Width-1:0] wrData,
  input wire logic wrValid,
  output logic wrReady,
  output logic [Width-1:0] rdData,
  output logic rdValid,
  input wire logic rdReady
);
  localparam int AW = $clog2(Depth);
  logic [Width-1:0] mem [Depth];
  logic [AW:0] wrPtr_r;
  logic [AW:0] rdPtr_r;

  assign wrReady = (wrPtr_r[AW] == rdPtr_r[AW]) || (wrPtr_r[AW-1:0] != rdPtr_r[AW-1:0]);
  assign rdValid = wrPtr_r != rdPtr_r;
  assign rdData = mem[rdPtr_r[AW-1:0]];

  // storage write
  always_ff @(posedge ref_clk) begin
    if (wrValid && wrReady) begin
      mem[wrPtr_r[AW-1:0]] <= wrData;
    end
  end

  // pointers with a wrap bit for honest full and empty
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (wrValid && wrReady) begin
        wrPtr_r <= wrPtr_r + (AW+1)'(1);
      end
      if (rdValid && rdReady) begin
        rdPtr_r <= rdPtr_r + (AW+1)'(1);
      end
    end
  end
endmodule

module psc_host #(
  parameter int unsigned Cf2ckCycles = `PSC_CF2CK_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  psc_link_if.host link,
  input wire logic start,
  input wire psc_pkg::psc_len_t bitstreamBytes,
  input wire psc_pkg::psc_byte_t wrData,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic userClkRun,
  output logic busy_r,
  output logic userMode_r,
  output logic error_r
);
  function automatic psc_pkg::psc_cnt_t incSat(input psc_pkg::psc_cnt_t c);
    incSat = (&c) ? c : c + psc_pkg::psc_cnt_t'(1);
  endfunction

  // ----------------------------------------------------------------
  // synchronisers for status, done and init_complete
  // ----------------------------------------------------------------
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] s3_r;
  logic [2:0] flt_r;
  logic [2:0] prev_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= `PSC_HSYNC_RST;
      s2_r <= `PSC_HSYNC_RST;
      s3_r <= `PSC_HSYNC_RST;
      flt_r <= `PSC_HSYNC_RST;
      prev_r <= `PSC_HSYNC_RST;
    end else begin
      s1_r <= {link.status_n, link.config_done, link.init_complete};
      s2_r <= s1_r;
      s3_r <= s2_r;
      flt_r <= (s2_r & ~(s2_r ^ s3_r)) | (flt_r & (s2_r ^ s3_r));
      prev_r <= flt_r;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  psc_pkg::psc_host_e state_r;
  psc_pkg::psc_cnt_t cnt_r;
  psc_pkg::psc_cnt_t stCnt_r;
  psc_pkg::psc_len_t bytesLeft_r;
  psc_pkg::psc_byte_t sh_r;
  logic [3:0] bitsLeft_r;
  logic [3:0] div_r;
  logic [1:0] tail_r;
  psc_pkg::psc_byte_t fifoData;
  logic fifoValid;
  logic pop;
  logic halfDone;

  assign halfDone = div_r == `PSC_CONFIG_CLOCK_HALF - 4'h1;
  assign pop = state_r == psc_pkg::HST_SHIFT && bitsLeft_r == 4'h0 && !link.config_clock
               && bytesLeft_r != '0 && fifoValid;

  psc_fifo #(.Width(`PSC_BYTE_W), .Depth(`PSC_FIFO_DEPTH)) fifo (
    .ref_clk(ref_clk), .reset_n(reset_n), .wrData(wrData), .wrValid(wrValid),
    .wrReady(wrReady), .rdData(fifoData), .rdValid(fifoValid), .rdReady(pop)
  );

  // status-high timer for the post-release gap
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stCnt_r <= '0;
    end else begin
      stCnt_r <= flt_r[2] ? incSat(stCnt_r) : '0;
    end
  end

  // request, shifting and completion sequence
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= psc_pkg::HST_IDLE;
      cnt_r <= '0;
      div_r <= 4'h0;
      tail_r <= 2'h0;
      bitsLeft_r <= 4'h0;
      bytesLeft_r <= '0;
      sh_r <= 8'h00;
      link.config_request_n <= 1'h1;
      link.config_clock <= 1'h0;
      link.serial_config_data <= 1'h0;
    end else if (start) begin
      state_r <= psc_pkg::HST_REQ;
      cnt_r <= '0;
      link.config_request_n <= 1'h0;
      link.config_clock <= 1'h0;
    end else begin
      unique case (state_r)
        psc_pkg::HST_IDLE, psc_pkg::HST_USER, psc_pkg::HST_ERR: begin
          link.config_clock <= 1'h0;
          link.serial_config_data <= 1'h0;
        end
        psc_pkg::HST_REQ: begin
          cnt_r <= incSat(cnt_r);
          if (cnt_r >= psc_pkg::psc_cnt_t'(`PSC_CFG_CYC - 1)) begin
            link.config_request_n <= 1'h1;
            state_r <= psc_pkg::HST_WAIT;
            cnt_r <= '0;
          end
        end
        psc_pkg::HST_WAIT: begin
          cnt_r <= incSat(cnt_r);
          bytesLeft_r <= bitstreamBytes;
          bitsLeft_r <= 4'h0;
          div_r <= 4'h0;
          if (cnt_r >= psc_pkg::psc_cnt_t'(Cf2ckCycles - 1)
              && stCnt_r >= psc_pkg::psc_cnt_t'(`PSC_ST2CK_CYC - 1)) begin
            state_r <= psc_pkg::HST_SHIFT;
          end
        end
        psc_pkg::HST_SHIFT: begin
          if (prev_r[2] && !flt_r[2]) begin
            state_r <= psc_pkg::HST_ERR;
          end else if (pop) begin
            sh_r <= fifoData;
            link.serial_config_data <= fifoData[0];
            bitsLeft_r <= 4'h8;
            bytesLeft_r <= bytesLeft_r - psc_pkg::psc_len_t'(1);
            div_r <= 4'h0;
          end else if (bitsLeft_r != 4'h0) begin
            div_r <= halfDone ? 4'h0 : div_r + 4'h1;
            if (halfDone && !link.config_clock) begin
              link.config_clock <= 1'h1;
            end else if (halfDone) begin
              link.config_clock <= 1'h0;
              sh_r <= {1'h0, sh_r[7:1]};
              link.serial_config_data <= sh_r[1];
              bitsLeft_r <= bitsLeft_r - 4'h1;
            end
          end else if (bytesLeft_r == '0) begin
            state_r <= psc_pkg::HST_TAIL;
            tail_r <= 2'h0;
            div_r <= 4'h0;
          end
        end
        psc_pkg::HST_TAIL: begin
          div_r <= halfDone ? 4'h0 : div_r + 4'h1;
          if (halfDone && !link.config_clock) begin
            link.config_clock <= 1'h1;
          end else if (halfDone) begin
            link.config_clock <= 1'h0;
            tail_r <= tail_r + 2'h1;
            if (tail_r == 2'h1) begin
              state_r <= flt_r[1] ? psc_pkg::HST_INIT : psc_pkg::HST_ERR;
            end
          end
        end
        psc_pkg::HST_INIT: begin
          if (!flt_r[2]) begin
            state_r <= psc_pkg::HST_ERR;
          end else if (flt_r[0]) begin
            state_r <= psc_pkg::HST_USER;
          end
        end
        default: begin
          state_r <= psc_pkg::HST_ERR;
        end
      endcase
    end
  end

  // free-running startup clock from a divider
  logic [3:0] uDiv_r;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      uDiv_r <= 4'h0;
      link.user_startup_clock <= 1'h0;
    end else if (userClkRun) begin
      uDiv_r <= (uDiv_r == `PSC_USRCLK_HALF - 4'h1) ? 4'h0 : uDiv_r + 4'h1;
      if (uDiv_r == `PSC_USRCLK_HALF - 4'h1) begin
        link.user_startup_clock <= !link.user_startup_clock;
      end
    end
  end

  // status outputs for the host user
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_r <= 1'h0;
      userMode_r <= 1'h0;
      error_r <= 1'h0;
    end else begin
      busy_r <= state_r != psc_pkg::HST_IDLE && state_r != psc_pkg::HST_USER
                && state_r != psc_pkg::HST_ERR;
      userMode_r <= state_r == psc_pkg::HST_USER;
      error_r <= state_r == psc_pkg::HST_ERR;
    end
  end
endmodule

// ---- psc_link_if.sv ----
// configuration pins between host and device, with pull-ups resolved
interface psc_link_if;
  logic config_request_n;
  logic config_clock;
  logic serial_config_data;
  logic user_startup_clock;
  logic statusOut;
  logic statusOe;
  logic doneOut;
  logic doneOe;
  logic init_complete;
  logic status_n;
  logic config_done;

  // open-drain lines float high unless pulled low
  assign status_n = (statusOe && !statusOut) ? 1'h0 : 1'h1;
  assign config_done = (doneOe && !doneOut) ? 1'h0 : 1'h1;

  modport dev (
    input config_request_n, config_clock, serial_config_data, user_startup_clock,
    input status_n, config_done,
    output statusOut, statusOe, doneOut, doneOe, init_complete
  );
  modport host (
    output config_request_n, config_clock, serial_config_data, user_startup_clock,
    input status_n, config_done, init_complete
  );
endinterface

// ---- psc_link_sva.sv ----
// checker for the configuration link pins between host and device
module psc_link_sva #(
  parameter int unsigned StatusMinCycles = 40,
  parameter int unsigned StartupCycles = 60
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic config_request_n,
  input wire logic config_clock,
  input wire logic status_n,
  input wire logic config_done,
  input wire logic init_complete
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  int unsigned lowCnt;
  int unsigned clkAge;
  int unsigned doneAge;
  // ages of status low, last link clock rise and done rise
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lowCnt <= 0;
      clkAge <= 0;
      doneAge <= 0;
    end else begin
      lowCnt <= status_n ? 0 : lowCnt + 1;
      clkAge <= $rose(config_clock) ? 0 : clkAge + 1;
      doneAge <= $rose(config_done) ? 0 : doneAge + 1;
    end
  end
  sequence s_reqFall; $fell(config_request_n); endsequence
  property p_doneLow; s_reqFall |-> ##[0:99] !config_done; endproperty
  a_doneLow: assert property (p_doneLow) else $error("done not pulled low");
  property p_statusLow; s_reqFall |-> ##[0:99] !status_n; endproperty
  a_statusLow: assert property (p_statusLow) else $error("status not pulled low");
  property p_statusWidth; $rose(status_n) |-> lowCnt >= StatusMinCycles - 8; endproperty
  a_statusWidth: assert property (p_statusWidth) else $error("status pulse short");
  property p_doneHold; (!status_n)[*3] |-> !config_done; endproperty
  a_doneHold: assert property (p_doneHold) else $error("done high in reset");
  property p_doneCause; $rose(config_done) |-> clkAge <= 12; endproperty
  a_doneCause: assert property (p_doneCause) else $error("done rose without clock");
  property p_startup; $rose(init_complete) |-> doneAge >= StartupCycles; endproperty
  a_startup: assert property (p_startup) else $error("startup too short");
  property p_userLevels; init_complete && config_request_n |-> config_done && status_n; endproperty
  a_userLevels: assert property (p_userLevels) else $error("user mode levels wrong");
  property p_restart; s_reqFall and init_complete |-> ##[1:20] !init_complete; endproperty
  a_restart: assert property (p_restart) else $error("no restart from user");
  property p_release; $rose(config_request_n) |-> ##[0:60] status_n; endproperty
  a_release: assert property (p_release) else $error("status not released");
  property p_halt; $fell(status_n) && config_request_n |-> (!config_done)[*8]; endproperty
  a_halt: assert property (p_halt) else $error("done rose after halt");
endmodule

// ---- psc_params.svh ----
// timing, width and reset constants for the passive serial configuration link
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH
// Overview of operation
// - request low in user mode restarts configuration
// - status held low through power-on delay
// - done stays low until bitstream complete
// - done driven low within 500 ns
// - status driven low within 500 ns
// - host holds request low 500 ns minimum
// - status low 45 us min, 230 us max
// - status released within 230 us of request
// - host waits 230 us before first clock
// - host waits 2 us after status high
// - internal oscillator startup takes 300 to 650 us
// - user clock: 4 periods, then 3192 edges
// - host clock at most 133 MHz
// - one bit per clock until done
// - shared status fall halts every device
// - tied done lines start devices together
// - cable host restarts manually after error
// - cable mode ignores user startup clock
// - host parks clock and data in user mode
// - host shifts each byte LSB first
// - device samples data on rising clock
// - host gives two falling edges after done
// - device raises init_complete in user mode

// ----------------------------------------------------------------
// clock and times in their own units
// ----------------------------------------------------------------
`define PSC_CLK_PS 5000
`define PSC_T_CFG_NS 500
`define PSC_T_STATUS_MIN_US 45
`define PSC_T_CF2CK_US 230
`define PSC_T_ST2CK_US 2
`define PSC_T_CD2UM_MIN_US 300
`define PSC_T_POR_US 100
`define PSC_T_CLK_MIN_PS 7500
`define PSC_CD2CU_PERIODS 4
`define PSC_USERCLK_EDGES 3192

// ----------------------------------------------------------------
// derived cycle counts (minimums round up)
// ----------------------------------------------------------------
`define PSC_CEIL_CYC(ps) (((ps) + `PSC_CLK_PS - 1) / `PSC_CLK_PS)
`define PSC_CFG_CYC `PSC_CEIL_CYC(`PSC_T_CFG_NS * 1000)
`define PSC_STATUS_MIN_CYC `PSC_CEIL_CYC(`PSC_T_STATUS_MIN_US * 1000000)
`define PSC_CF2CK_CYC `PSC_CEIL_CYC(`PSC_T_CF2CK_US * 1000000)
`define PSC_ST2CK_CYC `PSC_CEIL_CYC(`PSC_T_ST2CK_US * 1000000)
`define PSC_CD2UM_CYC `PSC_CEIL_CYC(`PSC_T_CD2UM_MIN_US * 1000000)
`define PSC_POR_CYC `PSC_CEIL_CYC(`PSC_T_POR_US * 1000000)
`define PSC_CD2CU_CYC `PSC_CEIL_CYC(`PSC_CD2CU_PERIODS * `PSC_T_CLK_MIN_PS)

// ----------------------------------------------------------------
// widths, dividers, reset values
// ----------------------------------------------------------------
`define PSC_CNT_W 17
`define PSC_LEN_W 24
`define PSC_BYTE_W 8
`define PSC_FIFO_DEPTH 16
`define PSC_CONFIG_CLOCK_HALF 4'h4
`define PSC_USRCLK_HALF 4'h8
`define PSC_SYNC_RST 6'h20 // reset levels: request high, the rest low
`define PSC_HSYNC_RST 3'h0 // status, done and init all low in reset
`endif

// ---- psc_pkg.sv ----
// types shared by both ends of the configuration link
`include "psc_params.svh"
package psc_pkg;
  typedef logic [`PSC_CNT_W-1:0] psc_cnt_t;
  typedef logic [`PSC_LEN_W-1:0] psc_len_t;
  typedef logic [`PSC_BYTE_W-1:0] psc_byte_t;

  // device sequence, gray along power-up to user mode
  typedef enum logic [2:0] {
    DEV_POR = 3'h0, DEV_RESET = 3'h1, DEV_CONFIG = 3'h3, DEV_INIT = 3'h2,
    DEV_START = 3'h6, DEV_USER = 3'h7, DEV_HALT = 3'h5
  } psc_dev_e;

  // host sequence, gray along request to user mode
  typedef enum logic [2:0] {
    HST_IDLE = 3'h0, HST_REQ = 3'h1, HST_WAIT = 3'h3, HST_SHIFT = 3'h2,
    HST_TAIL = 3'h6, HST_INIT = 3'h7, HST_USER = 3'h5, HST_ERR = 3'h4
  } psc_host_e;
endpackage
